// ---- rtdma_pkg.sv ----
// Operation
// R1: unused channel is never converted; its quality shows the unused mark
// R2: modes unused, 0-20 mA, 0-2000 ohm, Pt100, Pt250, Ni100, Ni120, Ni250, Cu10
// R3: sensor modes turn resistance into temperature, default span -40 to 200 C
// R4: per channel unit (default dimensionless) and four limit settings at extremes
// R5: celsius unit skips scaling; value limits only narrow the temperature span
// R6: dimensionless unit maps input min/max linearly onto value min/max
// R7: current mode with ampere unit skips scaling; limits only narrow 0-20 mA
// R8: resistance mode with ohm unit skips scaling; limits only narrow 0-2000 ohm
// R9: input beyond hardware limits outputs the min or max and degrades quality
// R10: every enabled channel reports a measurement chain break
// R11: reference current off by over 20% discards the sample, output invalid
// R12: invalid status clears once a sample is back within the offset
// R13: range code 0 normal, 1 high, 2 low, 3 high-high, 4 low-low
// R14: each channel supervises its limits and reports every range code change
// R15: alarm is set while any channel sits in high-high or low-low
// R16: warning is set while any channel sits in high or low
// R17: past value max/min quality is out of range; extreme shown past hysteresis
// R18: hysteresis lies beyond the range extreme, allowing a slight overshoot
// R19: integral deadband: report only when accumulated change reaches the deadband
// R20: deadband unit 0.001 percent-seconds of span; divide by 100000
// R21: crossing high-high/low-low gives codes 3/4, else high/low gives 1/2
// R22: after a report the reported value is the new reference, integral restarts
package rtdma_pkg;
   localparam int NUM_CH = 8;
   localparam int CH_W = 3;
   localparam int QW = 5;
   // register index within a channel window, byte address = idx * 4
   localparam logic [3:0] REG_MODE = 4'h0;
   localparam logic [3:0] REG_UNIT = 4'h1;
   localparam logic [3:0] REG_IN_MIN = 4'h2;
   localparam logic [3:0] REG_IN_MAX = 4'h3;
   localparam logic [3:0] REG_VAL_MIN = 4'h4;
   localparam logic [3:0] REG_VAL_MAX = 4'h5;
   localparam logic [3:0] REG_HH = 4'h6;
   localparam logic [3:0] REG_HI = 4'h7;
   localparam logic [3:0] REG_LO = 4'h8;
   localparam logic [3:0] REG_LL = 4'h9;
   localparam logic [3:0] REG_HYST = 4'ha;
   localparam logic [3:0] REG_DEADBAND = 4'hb;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam logic [3:0] REG_VALUE = 4'hd;
   localparam logic [3:0] REG_REPORTED = 4'he;
   localparam logic [11:0] CH_WIN_END = 12'h200;
   localparam logic [11:0] GLOBAL_OFF = 12'h400;
   // quality bit positions
   localparam int Q_UNUSED = 0;
   localparam int Q_HWLIM = 1;
   localparam int Q_INVALID = 2;
   localparam int Q_OOR = 3;
   localparam int Q_BREAK = 4;
   localparam logic signed [31:0] INT_MAX = 32'sh7fff_ffff;
   localparam logic signed [31:0] INT_MIN = 32'sh8000_0001;
   localparam logic signed [31:0] HYST_RST = 32'sh0000_0000;
   localparam logic [15:0] DEADBAND_RST = 16'h2710;
   // engineering units: uA, milliohm, 0.01 degC
   localparam longint TEMP_SCALE = 100;
   localparam longint TEMP_HW_MAX = 20000;
   localparam longint TEMP_HW_MIN = -4000;
   localparam longint MA_SPAN_MAX = 20000;
   localparam longint MA_HW_MAX = 23000;
   localparam longint RES_MAX = 2000000;
   localparam longint REF_DEV_PCT = 20;
   localparam longint REF_EXP_MA = 1000;
   localparam longint REF_EXP_RTD = 500;
   localparam longint DB_DIV = 100000;
   localparam longint SMP_HZ = 10;
   localparam longint CLK_HZ = 50000000;
   localparam longint SCAN_PERIOD_US = 12500;
   localparam int SCAN_CYCLES = int'(SCAN_PERIOD_US * (CLK_HZ / 1000000));
   typedef enum logic [3:0] {
      MODE_UNUSED = 4'b0001, MODE_RES = 4'b0010, MODE_MA = 4'b0011,
      MODE_PT100 = 4'b1010, MODE_PT250 = 4'b1011, MODE_NI100 = 4'b1100,
      MODE_NI120 = 4'b1101, MODE_NI250 = 4'b1110, MODE_CU10 = 4'b1111
   } rtdma_mode_t;
   typedef enum logic [1:0] {
      UNIT_DIMLESS = 2'b00, UNIT_CELSIUS = 2'b01, UNIT_AMPERE = 2'b10, UNIT_OHM = 2'b11
   } rtdma_unit_t;
endpackage

// ---- rtdma_top.sv ----
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rtdma_top
   import rtdma_pkg::*;
#(
   parameter int SCAN_CYCLES_P = SCAN_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic conv_req,
   output logic [CH_W-1:0] conv_ch,
   input wire logic smp_valid,
   input wire logic [CH_W-1:0] smp_ch,
   input wire logic signed [31:0] smp_raw,
   input wire logic signed [31:0] smp_ref,
   input wire logic smp_break,
   output logic res_valid,
   output logic [CH_W-1:0] res_ch,
   output logic signed [31:0] channel_instant_value,
   output logic signed [31:0] channel_output_value,
   output logic [2:0] channel_range_code,
   output logic [QW-1:0] channel_quality,
   output logic range_event,
   output logic report_valid,
   output logic signed [31:0] channel_reported_value,
   output logic alarm,
   output logic warning
);
   rtdma_mode_t mode_reg [NUM_CH];
   rtdma_unit_t unit_reg [NUM_CH];
   logic signed [31:0] in_min_reg [NUM_CH];
   logic signed [31:0] in_max_reg [NUM_CH];
   logic signed [31:0] val_min_reg [NUM_CH];
   logic signed [31:0] val_max_reg [NUM_CH];
   logic signed [31:0] hh_reg [NUM_CH];
   logic signed [31:0] hi_reg [NUM_CH];
   logic signed [31:0] lo_reg [NUM_CH];
   logic signed [31:0] ll_reg [NUM_CH];
   logic signed [31:0] hyst_reg [NUM_CH];
   logic [15:0] db_reg [NUM_CH];
   logic signed [31:0] value_reg [NUM_CH];
   logic signed [31:0] rep_reg [NUM_CH];
   logic [2:0] range_reg [NUM_CH];
   logic [QW-1:0] qual_reg [NUM_CH];
   logic [63:0] acc_reg [NUM_CH];
   logic [19:0] scan_cnt_reg;
   logic [CH_W-1:0] scan_ch_reg;
   logic signed [31:0] chk_old_val_reg;
   rtdma_mode_t md;
   rtdma_unit_t un;
   logic ch_used, is_temp, native, ref_bad, hw_flag, oor, hit;
   logic signed [63:0] r0, slope, ref_exp, ref_dev, eng, dmin, dmax, emin, emax, den, inst64;
   logic signed [79:0] num;
   logic signed [31:0] inst, shown;
   logic [2:0] rng;
   logic [QW-1:0] qual_new;
   logic signed [63:0] diff;
   logic [63:0] acc_new;
   logic signed [111:0] lhs, rhs;
   logic any_alarm_c, any_warn_c;
   logic addr_ok, wr_en;
   logic [31:0] rd_c;
   logic [CH_W-1:0] a_ch;
   logic [3:0] a_idx;

   // scan pointer; unused channels get no conversion request
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scan_cnt_reg <= 20'h0_0000;
         scan_ch_reg <= 3'h0;
         conv_req <= 1'b0;
         conv_ch <= 3'h0;
      end
      else if (scan_cnt_reg == 20'(SCAN_CYCLES_P - 1))
      begin
         scan_cnt_reg <= 20'h0_0000;
         scan_ch_reg <= scan_ch_reg + 3'h1;
         conv_req <= mode_reg[scan_ch_reg] != MODE_UNUSED; // R1
         conv_ch <= scan_ch_reg;
      end
      else
      begin
         scan_cnt_reg <= scan_cnt_reg + 20'h0_0001;
         conv_req <= 1'b0;
      end
   end

   // engineering value, scaling, limits and deadband for the arriving sample
   always_comb
   begin
      md = mode_reg[smp_ch];
      un = unit_reg[smp_ch];
      ch_used = md != MODE_UNUSED;
      is_temp = md inside {MODE_PT100, MODE_PT250, MODE_NI100, MODE_NI120,
                           MODE_NI250, MODE_CU10};
      // linearised sensor tables: r0 in milliohm, slope in milliohm per degC
      case (md)
         MODE_PT100: begin r0 = 64'sd100000; slope = 64'sd385; end // R3
         MODE_PT250: begin r0 = 64'sd250000; slope = 64'sd963; end
         MODE_NI100: begin r0 = 64'sd100000; slope = 64'sd618; end
         MODE_NI120: begin r0 = 64'sd120000; slope = 64'sd742; end
         MODE_NI250: begin r0 = 64'sd250000; slope = 64'sd1545; end
         MODE_CU10: begin r0 = 64'sd9035; slope = 64'sd39; end
         default: begin r0 = 64'sd0; slope = 64'sd1; end
      endcase
      // reference check right after the input sample
      ref_exp = (md == MODE_MA) ? REF_EXP_MA : REF_EXP_RTD;
      ref_dev = 64'(smp_ref) - ref_exp;
      if (ref_dev < 0)
         ref_dev = -ref_dev;
      ref_bad = ref_dev * 100 > ref_exp * REF_DEV_PCT; // R11
      hw_flag = 1'b0;
      eng = 64'(smp_raw);
      dmin = 64'sd0;
      dmax = 64'sd0;
      if (md == MODE_MA) // R2
      begin
         dmax = MA_SPAN_MAX;
         if (eng > MA_HW_MAX)
         begin
            eng = MA_SPAN_MAX; // R9
            hw_flag = 1'b1;
         end
         else if (eng < 0)
            eng = 64'sd0;
      end
      else if (md == MODE_RES)
      begin
         dmax = RES_MAX;
         if (eng > RES_MAX)
         begin
            eng = RES_MAX; // R9
            hw_flag = 1'b1;
         end
      end
      else if (is_temp)
      begin
         dmin = TEMP_HW_MIN;
         dmax = TEMP_HW_MAX;
         eng = (eng - r0) * TEMP_SCALE / slope; // R3
         if (eng > TEMP_HW_MAX)
         begin
            eng = TEMP_HW_MAX; // R9
            hw_flag = 1'b1;
         end
         else if (eng < TEMP_HW_MIN)
         begin
            eng = TEMP_HW_MIN; // R9
            hw_flag = 1'b1;
         end
      end
      native = (md == MODE_MA && un == UNIT_AMPERE) || (md == MODE_RES && un == UNIT_OHM)
               || (is_temp && un == UNIT_CELSIUS);
      num = 80'sd0;
      den = 64'(in_max_reg[smp_ch]) - 64'(in_min_reg[smp_ch]);
      if (native)
      begin
         // bypass: limits can only shrink the fixed span
         emin = (64'(val_min_reg[smp_ch]) > dmin) ? 64'(val_min_reg[smp_ch]) : dmin; // R5 R7 R8
         emax = (64'(val_max_reg[smp_ch]) < dmax) ? 64'(val_max_reg[smp_ch]) : dmax;
         inst64 = eng;
      end
      else
      begin
         emin = 64'(val_min_reg[smp_ch]);
         emax = 64'(val_max_reg[smp_ch]);
         num = 80'(eng - 64'(in_min_reg[smp_ch])) * 80'(emax - emin);
         inst64 = (den == 0) ? emin : emin + 64'(num / 80'(den)); // R6
      end
      // saturate so the 32-bit value never wraps
      if (inst64 > 64'(INT_MAX))
         inst = INT_MAX;
      else if (inst64 < 64'(INT_MIN))
         inst = INT_MIN;
      else
         inst = 32'(inst64);
      oor = (64'(inst) > emax) || (64'(inst) < emin); // R17
      if (64'(inst) > emax + 64'(hyst_reg[smp_ch]))
         shown = 32'(emax); // R18
      else if (64'(inst) < emin - 64'(hyst_reg[smp_ch]))
         shown = 32'(emin);
      else
         shown = inst;
      // outer limits first so high-high wins over high
      if (shown >= hh_reg[smp_ch])
         rng = 3'h3; // R21 R13
      else if (shown <= ll_reg[smp_ch])
         rng = 3'h4;
      else if (shown >= hi_reg[smp_ch])
         rng = 3'h1;
      else if (shown <= lo_reg[smp_ch])
         rng = 3'h2;
      else
         rng = 3'h0;
      qual_new = '0;
      qual_new[Q_HWLIM] = hw_flag;
      qual_new[Q_OOR] = oor;
      qual_new[Q_BREAK] = smp_break; // R10
      qual_new[Q_INVALID] = ref_bad;
      // integral of |value - reference| per sample period
      diff = 64'(shown) - 64'(rep_reg[smp_ch]);
      if (diff < 0)
         diff = -diff;
      acc_new = acc_reg[smp_ch] + 64'(diff); // R19
      lhs = 112'(acc_new) * 112'(DB_DIV);
      rhs = 112'(emax - emin) * 112'(db_reg[smp_ch]) * 112'(SMP_HZ); // R20
      hit = lhs >= rhs;
   end

   // per channel state; a discarded sample leaves value and range untouched
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            value_reg[i] <= 32'sh0000_0000;
            rep_reg[i] <= 32'sh0000_0000;
            range_reg[i] <= 3'h0;
            qual_reg[i] <= 5'h01;
            acc_reg[i] <= 64'h0;
         end
      end
      else
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            if (mode_reg[i] == MODE_UNUSED)
            begin
               qual_reg[i] <= 5'h01; // R1
               range_reg[i] <= 3'h0;
               acc_reg[i] <= 64'h0;
            end
         end
         if (smp_valid && ch_used)
         begin
            if (ref_bad)
               qual_reg[smp_ch] <= qual_new & 5'h14; // R11
            else
            begin
               value_reg[smp_ch] <= shown;
               range_reg[smp_ch] <= rng; // R14
               qual_reg[smp_ch] <= qual_new; // R12
               if (hit)
               begin
                  rep_reg[smp_ch] <= shown; // R22
                  acc_reg[smp_ch] <= 64'h0;
               end
               else
                  acc_reg[smp_ch] <= acc_new;
            end
         end
      end
   end

   // result stream, one beat per sample of a used channel, discarded ones included
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         res_valid <= 1'b0;
         res_ch <= 3'h0;
         channel_instant_value <= 32'sh0000_0000;
         channel_output_value <= 32'sh0000_0000;
         channel_range_code <= 3'h0;
         channel_quality <= 5'h00;
         range_event <= 1'b0;
         report_valid <= 1'b0;
         channel_reported_value <= 32'sh0000_0000;
         chk_old_val_reg <= 32'sh0000_0000;
      end
      else
      begin
         res_valid <= smp_valid && ch_used;
         res_ch <= smp_ch;
         channel_instant_value <= inst;
         channel_output_value <= ref_bad ? value_reg[smp_ch] : shown;
         channel_range_code <= ref_bad ? range_reg[smp_ch] : rng;
         channel_quality <= ref_bad ? (qual_new & 5'h14) : qual_new;
         range_event <= smp_valid && ch_used && !ref_bad && rng != range_reg[smp_ch]; // R14
         report_valid <= smp_valid && ch_used && !ref_bad && hit; // R19
         channel_reported_value <= (!ref_bad && hit) ? shown : rep_reg[smp_ch];
         chk_old_val_reg <= value_reg[smp_ch];
      end
   end

   // module flags merged from every channel, one cycle behind the ranges
   always_comb
   begin
      any_alarm_c = 1'b0;
      any_warn_c = 1'b0;
      for (int i = 0; i < NUM_CH; i++)
      begin
         any_alarm_c = any_alarm_c | (range_reg[i] == 3'h3) | (range_reg[i] == 3'h4); // R15
         any_warn_c = any_warn_c | (range_reg[i] == 3'h1) | (range_reg[i] == 3'h2); // R16
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         alarm <= 1'b0;
         warning <= 1'b0;
      end
      else
      begin
         alarm <= any_alarm_c;
         warning <= any_warn_c;
      end
   end

   // apb decode; read data is captured in setup so it comes from a flop
   always_comb
   begin
      a_ch = paddr[8:6];
      a_idx = paddr[5:2];
      rd_c = 32'h0000_0000;
      addr_ok = 1'b1;
      if (paddr == GLOBAL_OFF)
         rd_c = {30'h0, warning, alarm};
      else if (paddr < CH_WIN_END && paddr[1:0] == 2'h0 && a_idx <= REG_REPORTED)
      begin
         if (a_idx == REG_MODE)
            rd_c = {28'h0, mode_reg[a_ch]};
         else if (a_idx == REG_UNIT)
            rd_c = {30'h0, unit_reg[a_ch]};
         else if (a_idx == REG_IN_MIN)
            rd_c = in_min_reg[a_ch];
         else if (a_idx == REG_IN_MAX)
            rd_c = in_max_reg[a_ch];
         else if (a_idx == REG_VAL_MIN)
            rd_c = val_min_reg[a_ch];
         else if (a_idx == REG_VAL_MAX)
            rd_c = val_max_reg[a_ch];
         else if (a_idx == REG_HH)
            rd_c = hh_reg[a_ch];
         else if (a_idx == REG_HI)
            rd_c = hi_reg[a_ch];
         else if (a_idx == REG_LO)
            rd_c = lo_reg[a_ch];
         else if (a_idx == REG_LL)
            rd_c = ll_reg[a_ch];
         else if (a_idx == REG_HYST)
            rd_c = hyst_reg[a_ch];
         else if (a_idx == REG_DEADBAND)
            rd_c = {16'h0, db_reg[a_ch]};
         else if (a_idx == REG_STATUS)
            rd_c = {24'h0, qual_reg[a_ch], range_reg[a_ch]};
         else if (a_idx == REG_VALUE)
            rd_c = value_reg[a_ch];
         else
            rd_c = rep_reg[a_ch];
      end
      else
         addr_ok = 1'b0;
      wr_en = psel && penable && pready && pwrite && !pslverr;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         if (psel && !penable)
            prdata <= addr_ok ? rd_c : 32'h0000_0000;
      end
   end

   // settings; range and limit defaults sit at the extremes, hysteresis resets to 0 and deadband to 10000
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         for (int i = 0; i < NUM_CH; i++)
         begin
            mode_reg[i] <= MODE_UNUSED; // R1
            unit_reg[i] <= UNIT_DIMLESS; // R4
            in_min_reg[i] <= INT_MIN;
            in_max_reg[i] <= INT_MAX;
            val_min_reg[i] <= INT_MIN;
            val_max_reg[i] <= INT_MAX;
            hh_reg[i] <= INT_MAX;
            hi_reg[i] <= INT_MAX;
            lo_reg[i] <= INT_MIN;
            ll_reg[i] <= INT_MIN;
            hyst_reg[i] <= HYST_RST;
            db_reg[i] <= DEADBAND_RST;
         end
      end
      else if (wr_en && paddr < CH_WIN_END)
      begin
         case (a_idx)
            REG_MODE: mode_reg[a_ch] <= rtdma_mode_t'(pwdata[3:0]);
            REG_UNIT: unit_reg[a_ch] <= rtdma_unit_t'(pwdata[1:0]);
            REG_IN_MIN: in_min_reg[a_ch] <= pwdata;
            REG_IN_MAX: in_max_reg[a_ch] <= pwdata;
            REG_VAL_MIN: val_min_reg[a_ch] <= pwdata;
            REG_VAL_MAX: val_max_reg[a_ch] <= pwdata;
            REG_HH: hh_reg[a_ch] <= pwdata;
            REG_HI: hi_reg[a_ch] <= pwdata;
            REG_LO: lo_reg[a_ch] <= pwdata;
            REG_LL: ll_reg[a_ch] <= pwdata;
            REG_HYST: hyst_reg[a_ch] <= pwdata;
            REG_DEADBAND: db_reg[a_ch] <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_used_smp;
      smp_valid && ch_used;
   endsequence
   sequence s_good_smp;
      s_used_smp ##0 !ref_bad;
   endsequence
   sequence s_bad_smp;
      s_used_smp ##0 ref_bad;
   endsequence

   AST_UNUSED_SILENT: assert property ((smp_valid && !ch_used) |=> !res_valid) // R1
      else $error("unused channel produced a result");
   // the stored value must survive the discarded sample, not only the shown one
   AST_BAD_DISCARD: assert property (s_bad_smp |=> res_valid && channel_quality[Q_INVALID]
      && channel_output_value == chk_old_val_reg
      && value_reg[res_ch] == chk_old_val_reg) // R11
      else $error("bad reference sample not discarded");
   AST_GOOD_VALID: assert property (s_good_smp |=> res_valid && !channel_quality[Q_INVALID]) // R12
      else $error("invalid status stuck after good sample");
   AST_RANGE_CODE: assert property (res_valid |-> channel_range_code <= 3'h4) // R13
      else $error("range code above four");
   AST_RANGE_EVT: assert property ((s_good_smp ##0 rng != range_reg[smp_ch]) |=> range_event) // R14
      else $error("range change not reported");
   // both directions: set while any channel qualifies, clear otherwise
   AST_ALARM: assert property (alarm == $past(any_alarm_c)) // R15
      else $error("alarm does not follow channel ranges");
   AST_WARN: assert property (warning == $past(any_warn_c)) // R16
      else $error("warning does not follow channel ranges");
   AST_BREAK: assert property ((s_used_smp ##0 smp_break) |=> channel_quality[Q_BREAK]) // R10
      else $error("circuit break not flagged");
   AST_REPORT: assert property (report_valid |-> channel_reported_value
      == channel_output_value) // R22
      else $error("report does not carry the shown value");
endmodule
`default_nettype wire

// ---- rtdma_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module rtdma_tb_top;
   import rtdma_pkg::*;
   logic clk, rst, psel, penable, pwrite, smp_valid, smp_break, got;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, conv_req, res_valid, range_event, report_valid, alarm, warning, e;
   logic [CH_W-1:0] conv_ch, smp_ch, res_ch;
   logic signed [31:0] smp_raw, smp_ref, channel_instant_value, channel_output_value;
   logic signed [31:0] channel_reported_value;
   logic [2:0] channel_range_code;
   logic [QW-1:0] channel_quality;
   int n_errors, checks, n0, n1;
   int rv[5] = '{16000, 19000, 4000, 1000, 10000};
   logic [2:0] rc[5] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h0};
   // sensor resistance at 0 degC for modes 11..15, milliohm
   int r0v[5] = '{250000, 100000, 120000, 250000, 9035};
   // short scan period keeps the round robin visible within a short run
   rtdma_top #(.SCAN_CYCLES_P(8)) u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .conv_req, .conv_ch, .smp_valid, .smp_ch, .smp_raw, .smp_ref,
      .smp_break, .res_valid, .res_ch, .channel_instant_value, .channel_output_value,
      .channel_range_code, .channel_quality, .range_event, .report_valid,
      .channel_reported_value, .alarm, .warning);
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic results;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] y);
      checks++;
      if (y !== x)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", nm, x, y);
      end
   endtask
   function automatic logic [11:0] ra(input int ch, input logic [3:0] idx);
      return 12'(ch * 64) + {6'h00, idx, 2'b00};
   endfunction
   // request held from setup until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 20)
      begin
         n_errors++;
         results();
      end
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rreg(input logic [11:0] a, input logic [31:0] x, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, x, rd);
   endtask
   // one sample pulse, then a bounded look for the result pulse
   task automatic samp(input int ch, input int raw, input int rf, input logic brk);
      int i;
      @(posedge clk);
      smp_valid <= 1'b1;
      smp_ch <= CH_W'(ch);
      smp_raw <= raw;
      smp_ref <= rf;
      smp_break <= brk;
      @(posedge clk);
      smp_valid <= 1'b0;
      got = 1'b0;
      for (i = 0; i < 3 && !got; i++)
      begin
         #1;
         got = (res_valid === 1'b1);
         if (!got)
            @(posedge clk);
      end
      if (got)
         chk("res_ch", 32'(ch), 32'(res_ch));
   endtask
   task automatic res(input logic [31:0] v, input logic [4:0] q);
      chk("res_valid", 32'h1, 32'(got));
      chk("value", v, channel_output_value);
      chk("quality", 32'(q), 32'(channel_quality));
   endtask
   task automatic cfg(input int ch, input int md, input int un);
      apb(1'b1, ra(ch, REG_MODE), 32'(md));
      apb(1'b1, ra(ch, REG_UNIT), 32'(un));
   endtask
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      smp_valid = 1'b0;
      smp_ch = '0;
      smp_raw = 0;
      smp_ref = 0;
      smp_break = 1'b0;
      n_errors = 0;
      checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rreg(ra(0, REG_MODE), 32'h1, "mode");
      rreg(ra(3, REG_UNIT), 32'h0, "unit");
      rreg(ra(3, REG_IN_MIN), INT_MIN, "in_min");
      rreg(ra(3, REG_IN_MAX), INT_MAX, "in_max");
      rreg(ra(3, REG_VAL_MIN), INT_MIN, "val_min");
      rreg(ra(3, REG_VAL_MAX), INT_MAX, "val_max");
      rreg(12'h300, 32'h0, "unmapped");
      chk("slverr", 32'h1, 32'(e));
      samp(0, 5000, 1000, 1'b0);
      chk("unused res_valid", 32'h0, 32'(got));
      $display("test reset and unused done");
      cfg(1, 3, 2);
      n0 = 0;
      n1 = 0;
      repeat (150)
      begin
         @(posedge clk);
         n0 += int'(conv_req === 1'b1 && conv_ch === 3'h0);
         n1 += int'(conv_req === 1'b1 && conv_ch === 3'h1);
      end
      chk("scan unused", 32'h0, 32'(n0));
      chk("scan used", 32'h1, 32'(n1 > 0));
      samp(1, 12000, 1000, 1'b0);
      res(12000, 5'h00);
      samp(1, 24000, 1000, 1'b0);
      res(20000, 5'h02);
      samp(1, 12000, 1300, 1'b0);
      res(20000, 5'h04);
      samp(1, 12000, 1000, 1'b0);
      res(12000, 5'h00);
      samp(1, 12000, 1000, 1'b1);
      chk("break", 32'h1, 32'(channel_quality[Q_BREAK]));
      $display("test current mode done");
      apb(1'b1, ra(1, REG_HH), 32'd18000);
      apb(1'b1, ra(1, REG_HI), 32'd15000);
      apb(1'b1, ra(1, REG_LO), 32'd5000);
      apb(1'b1, ra(1, REG_LL), 32'd2000);
      samp(1, 10000, 1000, 1'b0);
      for (int k = 0; k < 5; k++)
      begin
         samp(1, rv[k], 1000, 1'b0);
         chk("range", 32'(rc[k]), 32'(channel_range_code));
         chk("range_event", 32'h1, 32'(range_event));
         @(posedge clk);
         #1;
         chk("alarm", 32'(rc[k] > 3'h2), 32'(alarm));
         chk("warning", 32'(rc[k] == 3'h1 || rc[k] == 3'h2), 32'(warning));
      end
      samp(1, 1000, 1000, 1'b0);
      rreg(GLOBAL_OFF, 32'h1, "global");
      apb(1'b1, ra(1, REG_VAL_MAX), 32'd15000);
      apb(1'b1, ra(1, REG_HYST), 32'd500);
      samp(1, 15200, 1000, 1'b0);
      res(15200, 5'h08);
      samp(1, 16000, 1000, 1'b0);
      res(15000, 5'h08);
      chk("instant", 32'd16000, channel_instant_value);
      chk("no range_event", 32'h0, 32'(range_event));
      $display("test limits done");
      cfg(2, 3, 0);
      apb(1'b1, ra(2, REG_IN_MIN), 32'd4000);
      apb(1'b1, ra(2, REG_IN_MAX), 32'd20000);
      apb(1'b1, ra(2, REG_VAL_MIN), -32'sd36);
      apb(1'b1, ra(2, REG_VAL_MAX), 32'd36);
      samp(2, 12000, 1000, 1'b0);
      res(32'd0, 5'h00);
      samp(2, 4000, 1000, 1'b0);
      res(-32'sd36, 5'h00);
      cfg(3, 2, 3);
      samp(3, 1500000, 500, 1'b0);
      res(1500000, 5'h00);
      samp(3, 2100000, 500, 1'b0);
      res(2000000, 5'h02);
      cfg(4, 10, 1);
      samp(4, 100000, 500, 1'b0);
      res(32'd0, 5'h00);
      samp(4, 300000, 500, 1'b0);
      res(20000, 5'h02);
      samp(4, 80000, 500, 1'b0);
      res(-32'sd4000, 5'h02);
      for (int k = 0; k < 5; k++)
      begin
         cfg(6, 11 + k, 1);
         samp(6, r0v[k], 500, 1'b0);
         res(32'd0, 5'h00);
      end
      $display("test scaling done");
      cfg(5, 3, 2);
      apb(1'b1, ra(5, REG_DEADBAND), 32'd1);
      samp(5, 10000, 1000, 1'b0);
      chk("report", 32'h1, 32'(report_valid));
      chk("reported", 32'd10000, channel_reported_value);
      samp(5, 10001, 1000, 1'b0);
      chk("no report", 32'h0, 32'(report_valid));
      samp(5, 10001, 1000, 1'b0);
      chk("report", 32'h1, 32'(report_valid));
      chk("reported", 32'd10001, channel_reported_value);
      $display("test deadband done");
      results();
   end
endmodule
`default_nettype wire
